//--- lcdc_top.sv
/*
 Instruction handler of a bit-map LCD driver behind an AXI4-Lite slave.
 Assumes one clock, synchronous active-high reset, and a host that keeps
 to the documented instruction order; display memory lives outside.
*/
`timescale 1ns/1ps
`default_nettype none
module lcdc_top #(
    parameter int COL_W = 8                          // Column address width
) (
    input  wire logic        ref_clk,                // 125 MHz clock
    input  wire logic        srst,                   // Sync reset, active high
    input  wire logic [7:0]  s_axi_awaddr,           // Write address
    input  wire logic        s_axi_awvalid,          // Write address valid
    output logic             s_axi_awready,          // Write address ready
    input  wire logic [31:0] s_axi_wdata,            // Write data
    input  wire logic [3:0]  s_axi_wstrb,            // Write strobes
    input  wire logic        s_axi_wvalid,           // Write data valid
    output logic             s_axi_wready,           // Write data ready
    output logic [1:0]       s_axi_bresp,            // Write response
    output logic             s_axi_bvalid,           // Write response valid
    input  wire logic        s_axi_bready,           // Write response ready
    input  wire logic [7:0]  s_axi_araddr,           // Read address
    input  wire logic        s_axi_arvalid,          // Read address valid
    output logic             s_axi_arready,          // Read address ready
    output logic [31:0]      s_axi_rdata,            // Read data
    output logic [1:0]       s_axi_rresp,            // Read response
    output logic             s_axi_rvalid,           // Read data valid
    input  wire logic        s_axi_rready,           // Read data ready
    input  wire logic [7:0]  memRdData,              // Display memory read byte
    output logic             memWrEn,                // Display memory write pulse
    output logic [7:0]       memWrData,              // Display memory write byte
    output logic [COL_W-1:0] memColumn,              // Column address to memory
    output logic [3:0]       memPage,                // Page address to memory
    output logic [5:0]       startLine,              // Display start line
    output logic             oscRun,                 // Internal oscillator enable
    output logic             supplyRun,              // Regulator and follower enable
    output logic             boosterRun,             // Booster enable
    output logic [2:0]       boostMult,              // Boost multiple, 2..5 while stages is 5 or less
    output logic [7:0]       referenceLevel,         // Contrast code to reference
    output logic             driveOn,                // Common/segment waveform on
    output logic             segmentReverse,         // Segment order reversed
    output logic [2:0]       biasSel,                // Bias code
    output logic [5:0]       inversionCount,         // Line inversion count
    output logic [6:0]       dutyLines              // Active duty lines
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    lcdc_pkg::lcdc_axi_t axi_ff, nxt_axi;
    lcdc_pkg::lcdc_ctl_t ctl_ff, nxt_ctl;
    logic                memWr_ff, nxt_memWr;
    logic [7:0]          memWrData_ff, nxt_memWrData;

    // Boost multiple from code and fitted stages; never below 2
    function automatic logic [2:0] boost_mult(input logic [1:0] code, input logic [2:0] stg);
        logic [2:0] want;
        logic [2:0] shift;
        want  = 3'(code) + 3'h2;
        shift = lcdc_pkg::MAX_STAGES - stg;
        boost_mult = (want > shift + 3'h2) ? want - shift : 3'h2;
    endfunction

    // Apply the software reset defaults; display memory is not touched
    function automatic lcdc_pkg::lcdc_ctl_t soft_reset(input lcdc_pkg::lcdc_ctl_t c);
        lcdc_pkg::lcdc_ctl_t r;
        r           = c;
        r.column    = 8'h00;                         // RULE6
        r.startLine = 6'h00;                         // RULE6
        r.page      = 4'h0;                          // RULE6
        r.contrast  = lcdc_pkg::RST_CONTRAST;        // RULE7
        r.duty      = lcdc_pkg::RST_DUTY;            // RULE7
        r.bias      = lcdc_pkg::RST_BIAS;            // RULE7
        r.boostCode = lcdc_pkg::RST_BOOST;           // RULE7
        r.invCount  = 6'h00;                         // RULE7
        soft_reset  = r;
    endfunction

    logic        awGo, wGo, wrFire, rdFire, dataSel, cmdOk;
    logic [7:0]  wAddr, cmd;
    logic [31:0] rdVal, wVal;

    // ----------------------------------------------------------------
    // Bus slave and instruction decode
    // ----------------------------------------------------------------
    // Address and data may arrive in either order; held until both present
    always_comb begin
        nxt_axi       = axi_ff;
        nxt_ctl       = ctl_ff;
        nxt_memWr     = 1'b0;
        nxt_memWrData = memWrData_ff;
        awGo   = s_axi_awvalid && !axi_ff.awHeld && axi_ff.bus == lcdc_pkg::BUS_IDLE;
        wGo    = s_axi_wvalid && !axi_ff.wHeld && axi_ff.bus == lcdc_pkg::BUS_IDLE;
        if (awGo) begin
            nxt_axi.awHeld = 1'b1;
            nxt_axi.awAddr = s_axi_awaddr;
        end
        if (wGo) begin
            nxt_axi.wHeld = 1'b1;
            nxt_axi.wData = s_axi_wdata;
        end
        wAddr  = awGo ? s_axi_awaddr : axi_ff.awAddr;
        wVal   = wGo ? s_axi_wdata : axi_ff.wData;
        cmd    = wVal[7:0];
        wrFire = (awGo || axi_ff.awHeld) && (wGo || axi_ff.wHeld)
                 && axi_ff.bus == lcdc_pkg::BUS_IDLE && s_axi_wstrb_ok();
        rdFire = s_axi_arvalid && axi_ff.bus == lcdc_pkg::BUS_IDLE && !wrFire
                 && !axi_ff.awHeld && !axi_ff.wHeld;
        cmdOk  = wAddr == lcdc_pkg::ADDR_CMD;        // RULE24
        dataSel = wAddr == lcdc_pkg::ADDR_DATA;
        rdVal  = 32'h0000_0000;

        // Column moves one cycle after the write pulse, so the byte lands at the old column
        if (memWr_ff)
            nxt_ctl.column = ctl_ff.column + 8'h01;              // RULE2 RULE25
        if (wrFire) begin
            nxt_axi.awHeld = 1'b0;
            nxt_axi.wHeld  = 1'b0;
            nxt_axi.bus    = lcdc_pkg::BUS_WRESP;
            nxt_axi.bResp  = lcdc_pkg::RESP_OKAY;
            if (cmdOk) begin
                // Column set ignored in read-modify-write is the host's duty
                if (cmd[7:1] == lcdc_pkg::OP_RMW) begin          // RULE4
                    if (!cmd[0] && !ctl_ff.rmwOn) begin
                        nxt_ctl.rmwOn     = 1'b1;
                        nxt_ctl.rmwColumn = ctl_ff.column;
                    end else if (cmd[0] && ctl_ff.rmwOn) begin
                        nxt_ctl.rmwOn  = 1'b0;                   // RULE3
                        nxt_ctl.column = ctl_ff.rmwColumn;       // RULE3
                    end
                end else if (cmd == lcdc_pkg::OP_RESET) begin
                    nxt_ctl = soft_reset(ctl_ff);                // RULE8
                end else if (cmd[7:1] == lcdc_pkg::OP_SUPPLY) begin
                    nxt_ctl.supplyOn = cmd[0];                   // RULE10
                end else if (cmd[7:1] == lcdc_pkg::OP_WAVE) begin
                    nxt_ctl.waveOn = cmd[0];                     // RULE13
                end else if (cmd[7:1] == lcdc_pkg::OP_DISP) begin
                    nxt_ctl.dispOn = cmd[0];
                end else if (cmd[7:1] == lcdc_pkg::OP_WHOLE) begin
                    nxt_ctl.wholeOn = cmd[0];
                    if (cmd[0] && !ctl_ff.dispOn)
                        nxt_ctl.powerSave = 1'b1;                // RULE14
                    if (!cmd[0]) begin
                        nxt_ctl.powerSave = 1'b0;                // RULE16
                        if (ctl_ff.powerSave)
                            nxt_ctl.waveOn = 1'b0;               // RULE17
                    end
                end else if (cmd[7:1] == lcdc_pkg::OP_SEGORD) begin
                    nxt_ctl.segReverse = cmd[0];                 // RULE18
                end else if (cmd[7:2] == lcdc_pkg::OP_BOOST) begin
                    nxt_ctl.boostCode = cmd[1:0];                // RULE1
                end else if (cmd[7:3] == lcdc_pkg::OP_BIAS) begin
                    nxt_ctl.bias = cmd[2:1] == 2'b11 ? lcdc_pkg::RST_BIAS : cmd[2:0];
                end else if (cmd[7:4] == lcdc_pkg::OP_COLHI) begin
                    nxt_ctl.column = {cmd[3:0], ctl_ff.column[3:0]};
                end else if (cmd[7:4] == lcdc_pkg::OP_COLLO) begin
                    nxt_ctl.column = {ctl_ff.column[7:4], cmd[3:0]};
                end else if (cmd[7:4] == lcdc_pkg::OP_PAGE) begin
                    nxt_ctl.page = cmd[3:0];
                end else if (cmd[7:6] == lcdc_pkg::OP_START) begin
                    nxt_ctl.startLine = cmd[5:0];
                end
            end else if (dataSel) begin
                nxt_memWr      = 1'b1;                           // RULE24
                nxt_memWrData  = cmd;
            end else if (wAddr == lcdc_pkg::ADDR_CFG) begin
                nxt_ctl.contrast = wVal[7:0];
                nxt_ctl.invCount = wVal[13:8];
                nxt_ctl.stages   = wVal[18:16];
            end else if (wAddr == lcdc_pkg::ADDR_PINS) begin
                nxt_ctl.parallelSel = cmd[lcdc_pkg::PIN_PARALLEL];   // RULE22
                nxt_ctl.modeA       = cmd[lcdc_pkg::PIN_MODE_A];
                nxt_ctl.modeB       = cmd[lcdc_pkg::PIN_MODE_B];
            end else begin
                nxt_axi.bResp = lcdc_pkg::RESP_SLVERR;
            end
        end
        // Read path: data read goes through the holding latch (dummy read)
        if (rdFire) begin
            nxt_axi.bus   = lcdc_pkg::BUS_RRESP;
            nxt_axi.rResp = lcdc_pkg::RESP_OKAY;
            case (s_axi_araddr)
                lcdc_pkg::ADDR_DATA: begin
                    if (ctl_ff.parallelSel) begin                // RULE23
                        rdVal             = {24'h0, ctl_ff.readLatch};
                        nxt_ctl.readLatch = memRdData;
                        if (!ctl_ff.rmwOn)
                            nxt_ctl.column = ctl_ff.column + 8'h01;  // RULE25
                    end
                end
                lcdc_pkg::ADDR_STATUS: begin
                    if (ctl_ff.parallelSel)                      // RULE23
                        rdVal = {22'h0, ctl_ff.powerSave, ctl_ff.rmwOn, ctl_ff.supplyOn,
                                 ctl_ff.waveOn, ctl_ff.dispOn, ctl_ff.wholeOn,
                                 ctl_ff.segReverse, 1'b0, ctl_ff.boostCode};
                end
                lcdc_pkg::ADDR_CFG:
                    rdVal = {13'h0, ctl_ff.stages, 2'h0, ctl_ff.invCount, ctl_ff.contrast};
                lcdc_pkg::ADDR_PINS:
                    rdVal = {29'h0, ctl_ff.modeB, ctl_ff.modeA, ctl_ff.parallelSel};
                default:
                    nxt_axi.rResp = lcdc_pkg::RESP_SLVERR;
            endcase
            nxt_axi.rData = rdVal;
        end
        case (axi_ff.bus)
            lcdc_pkg::BUS_WRESP: if (s_axi_bready) nxt_axi.bus = lcdc_pkg::BUS_IDLE;
            lcdc_pkg::BUS_RRESP: if (s_axi_rready) nxt_axi.bus = lcdc_pkg::BUS_IDLE;
            default: ;
        endcase
    end

    // Strobes are not checked; partial writes still accepted
    function automatic logic s_axi_wstrb_ok();
        s_axi_wstrb_ok = 1'b1;
    endfunction

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            axi_ff             <= '0;
            ctl_ff             <= '0;
            ctl_ff.contrast    <= lcdc_pkg::RST_CONTRAST;
            ctl_ff.duty        <= lcdc_pkg::RST_DUTY;
            ctl_ff.bias        <= lcdc_pkg::RST_BIAS;
            ctl_ff.boostCode   <= lcdc_pkg::RST_BOOST;
            ctl_ff.stages      <= lcdc_pkg::MAX_STAGES;
            ctl_ff.parallelSel <= 1'b1;
            memWr_ff           <= 1'b0;
            memWrData_ff       <= 8'h00;
        end else begin
            axi_ff       <= nxt_axi;
            ctl_ff       <= nxt_ctl;
            memWr_ff     <= nxt_memWr;
            memWrData_ff <= nxt_memWrData;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all from flip-flops except s_axi_arready, which also decodes the write valids
    // ----------------------------------------------------------------
    logic             oscRun_ff, supplyRun_ff, boosterRun_ff, driveOn_ff;
    logic [2:0]       boostMult_ff;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            oscRun_ff     <= 1'b0;
            supplyRun_ff  <= 1'b0;
            boosterRun_ff <= 1'b0;
            driveOn_ff    <= 1'b0;
            boostMult_ff  <= 3'h5;
        end else begin
            oscRun_ff     <= !nxt_ctl.powerSave;                           // RULE15
            supplyRun_ff  <= nxt_ctl.supplyOn && !nxt_ctl.powerSave;       // RULE15
            boosterRun_ff <= nxt_ctl.supplyOn && !nxt_ctl.powerSave;       // RULE11
            driveOn_ff    <= nxt_ctl.waveOn && !nxt_ctl.powerSave;         // RULE15 RULE17
            boostMult_ff  <= boost_mult(nxt_ctl.boostCode, nxt_ctl.stages); // RULE1
        end
    end

    assign s_axi_awready  = !axi_ff.awHeld && axi_ff.bus == lcdc_pkg::BUS_IDLE;
    assign s_axi_wready   = !axi_ff.wHeld && axi_ff.bus == lcdc_pkg::BUS_IDLE;
    assign s_axi_arready  = axi_ff.bus == lcdc_pkg::BUS_IDLE && !axi_ff.awHeld
                            && !axi_ff.wHeld && !(s_axi_awvalid && s_axi_wvalid);
    assign s_axi_bvalid   = axi_ff.bus == lcdc_pkg::BUS_WRESP;
    assign s_axi_bresp    = axi_ff.bResp;
    assign s_axi_rvalid   = axi_ff.bus == lcdc_pkg::BUS_RRESP;
    assign s_axi_rresp    = axi_ff.rResp;
    assign s_axi_rdata    = axi_ff.rData;

    // Display memory side
    assign memWrEn        = memWr_ff;
    assign memWrData      = memWrData_ff;
    assign memColumn      = COL_W'(ctl_ff.column);
    assign memPage        = ctl_ff.page;
    assign startLine      = ctl_ff.startLine;

    // Analog enables and panel settings
    assign oscRun         = oscRun_ff;
    assign supplyRun      = supplyRun_ff;
    assign boosterRun     = boosterRun_ff;
    assign boostMult      = boostMult_ff;
    assign referenceLevel = ctl_ff.contrast;                               // RULE19
    assign driveOn        = driveOn_ff;
    assign segmentReverse = ctl_ff.segReverse;
    assign biasSel        = ctl_ff.bias;
    assign inversionCount = ctl_ff.invCount;
    assign dutyLines      = ctl_ff.duty;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_boost_needs_osc: assert property (@(posedge ref_clk) disable iff (srst)   // RULE11
        boosterRun |-> oscRun) else $error("booster running without oscillator");

    a_save_outputs_off: assert property (@(posedge ref_clk) disable iff (srst)  // RULE15
        ctl_ff.powerSave |-> !driveOn && !supplyRun) else $error("drive active in power save");

    a_rmw_read_holds: assert property (@(posedge ref_clk) disable iff (srst)    // RULE2
        rdFire && ctl_ff.rmwOn |=> $stable(ctl_ff.column)) else $error("rmw read moved column");

    a_save_entry: assert property (@(posedge ref_clk) disable iff (srst)        // RULE14
        wrFire && cmdOk && cmd == 8'hA5 && !ctl_ff.dispOn |=> ctl_ff.powerSave)
        else $error("power save not entered");

    a_save_release: assert property (@(posedge ref_clk) disable iff (srst)      // RULE16
        wrFire && cmdOk && cmd == 8'hA4 |=> !ctl_ff.powerSave ##1 oscRun)
        else $error("power save not released");

    a_reset_defaults: assert property (@(posedge ref_clk) disable iff (srst)    // RULE7
        wrFire && cmdOk && cmd == 8'hE2 && !(rdFire) |=> referenceLevel == 8'hFF
        && biasSel == 3'h6 && memColumn == '0) else $error("soft reset defaults wrong");

    a_wave_after_save: assert property (@(posedge ref_clk) disable iff (srst)   // RULE17
        $fell(ctl_ff.powerSave) |-> !ctl_ff.waveOn) else $error("drive back before enable");

    a_serial_no_read: assert property (@(posedge ref_clk) disable iff (srst)    // RULE23
        rdFire && !ctl_ff.parallelSel && s_axi_araddr == 8'h04 |=> s_axi_rdata == 32'h0)
        else $error("serial mode returned data");

    a_supply_cmd: assert property (@(posedge ref_clk) disable iff (srst)        // RULE10
        wrFire && cmdOk && cmd[7:1] == lcdc_pkg::OP_SUPPLY && !ctl_ff.powerSave
        |=> supplyRun == $past(cmd[0])) else $error("supply did not follow instruction");

    // Main scenarios: RMW round trip, power save in and out, data write, soft reset
    c_rmw_cycle: cover property (@(posedge ref_clk) ctl_ff.rmwOn ##[1:50] !ctl_ff.rmwOn);
    c_save: cover property (@(posedge ref_clk) $rose(ctl_ff.powerSave));
    c_save_release: cover property (@(posedge ref_clk) $fell(ctl_ff.powerSave));
    c_data_write: cover property (@(posedge ref_clk) memWrEn);
    c_soft_reset: cover property (@(posedge ref_clk) wrFire && cmdOk && cmd == lcdc_pkg::OP_RESET);
endmodule // lcdc_top
`default_nettype wire

//--- lcdc_pkg.sv
/*
 Package for the LCD driver instruction handler: register offsets, field positions,
 instruction codes, reset values and shared types.
 Assumes an AXI4-Lite master with 32-bit data; one clock, synchronous reset.
*/
//
// Behaviour
// [RULE1] Booster code 00..11 maps 2..5 times, shifted
// [RULE2] RMW: write advances column, read holds
// [RULE3] RMW end restores column held at entry
// [RULE4] RMW instruction lowest bit: 0 enter, 1 end
// [RULE5] Host avoids column set during RMW
// [RULE6] Reset clears column, start line, page
// [RULE7] Reset: contrast FF, 1/88, 1/10, 5x, inversion 0
// [RULE8] Reset leaves display memory untouched
// [RULE9] Host must pulse hardware reset at power-up
// [RULE10] Supply instruction bit0 runs or stops supply
// [RULE11] Boosting only while oscillator runs
// [RULE12] Host keeps supply off with external drive
// [RULE13] Waveform instruction bit0 enables drive output
// [RULE14] Display off then whole-on enters power save
// [RULE15] Power save stops oscillator, supply, outputs high
// [RULE16] Whole-display-off ends power save
// [RULE17] Outputs stay high until waveform re-enabled
// [RULE18] Segment order bit0: normal or reversed
// [RULE19] Contrast code selects 201 levels, FF full
// [RULE20] Host writes contrast codes 0x37 or above
// [RULE21] Contrast needs supply pins not both high; referenceLevel ignores modeA and modeB
// [RULE22] Interface pin high parallel, low serial
// [RULE23] Serial mode gives no readback; the code still returns the CFG and PINS registers
// [RULE24] Instructions only when command/data select low
// [RULE25] Normal mode: read and write advance column
`default_nettype none
package lcdc_pkg;
    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CMD    = 8'h00;  // Write: instruction byte
    localparam logic [7:0] ADDR_DATA   = 8'h04;  // Write: data byte, read: data byte
    localparam logic [7:0] ADDR_STATUS = 8'h08;  // Read: block state
    localparam logic [7:0] ADDR_CFG    = 8'h0C;  // Contrast, inversion, capacitor stages
    localparam logic [7:0] ADDR_PINS   = 8'h10;  // Strap-like pins: interface, supply mode
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------------------------------
    // Instruction codes
    // ----------------------------------------------------------------
    localparam logic [6:0] OP_RMW      = 7'h70;  // 1110000D
    localparam logic [7:0] OP_RESET    = 8'hE2;
    localparam logic [6:0] OP_SUPPLY   = 7'h10;  // 0010000D
    localparam logic [6:0] OP_WAVE     = 7'h11;  // 0010001D
    localparam logic [6:0] OP_WHOLE    = 7'h52;  // 1010010D
    localparam logic [6:0] OP_DISP     = 7'h57;  // 1010111D
    localparam logic [6:0] OP_SEGORD   = 7'h50;  // 1010000D
    localparam logic [5:0] OP_BOOST    = 6'h0C;  // 001100AA
    localparam logic [4:0] OP_BIAS     = 5'h15;  // 10101AAA
    localparam logic [3:0] OP_COLHI    = 4'h1;   // 0001hhhh
    localparam logic [3:0] OP_COLLO    = 4'h0;   // 0000llll
    localparam logic [3:0] OP_PAGE     = 4'hB;   // 1011pppp
    localparam logic [1:0] OP_START    = 2'h1;   // 01ssssss
    // ----------------------------------------------------------------
    // Reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_CONTRAST = 8'hFF;
    localparam logic [2:0] RST_BIAS     = 3'h6;  // 1/10 bias
    localparam logic [1:0] RST_BOOST    = 2'h3;  // 5 times
    localparam logic [6:0] RST_DUTY     = 7'h58; // 1/88
    localparam logic [2:0] MAX_STAGES   = 3'h5;
    localparam int CFG_CONTRAST_LSB = 0;
    localparam int CFG_INV_LSB      = 8;
    localparam int CFG_STAGES_LSB   = 16;
    localparam int PIN_PARALLEL     = 0;
    localparam int PIN_MODE_A       = 1;
    localparam int PIN_MODE_B       = 2;

    typedef enum logic [1:0] {
        BUS_IDLE  = 2'b00,
        BUS_WRESP = 2'b01,
        BUS_RRESP = 2'b10
    } lcdc_bus_t;

    typedef struct packed {
        lcdc_bus_t   bus;
        logic        awHeld;
        logic [7:0]  awAddr;
        logic        wHeld;
        logic [31:0] wData;
        logic [1:0]  bResp;
        logic [31:0] rData;
        logic [1:0]  rResp;
    } lcdc_axi_t;

    typedef struct packed {
        logic [7:0]  column;
        logic [7:0]  rmwColumn;
        logic        rmwOn;
        logic [5:0]  startLine;
        logic [3:0]  page;
        logic [7:0]  contrast;
        logic [5:0]  invCount;
        logic [6:0]  duty;
        logic [2:0]  bias;
        logic [1:0]  boostCode;
        logic [2:0]  stages;
        logic        supplyOn;
        logic        waveOn;
        logic        dispOn;
        logic        wholeOn;
        logic        segReverse;
        logic        powerSave;
        logic        parallelSel;
        logic        modeA;
        logic        modeB;
        logic [7:0]  readLatch;
    } lcdc_ctl_t;
endpackage
`default_nettype wire

//--- lcdc_mem_model.sv
/* Display memory stand-in on the far side of lcdc_top.
 Assumes a one-cycle write pulse and level column and page addresses. */
`timescale 1ns/1ps
`default_nettype none
module lcdc_mem_model (
    input  wire logic       ref_clk,    // Block clock
    input  wire logic       memWrEn,    // Write pulse
    input  wire logic [7:0] memWrData,  // Write byte
    input  wire logic [7:0] memColumn,  // Column address
    input  wire logic [3:0] memPage,    // Page address
    output logic      [7:0] memRdData   // Read byte
);
    logic [7:0] mem [0:4095];  // Unwritten cells stay X, like an unset RAM
    // Write on the pulse, read as a level
    always_ff @(posedge ref_clk) if (memWrEn) mem[{memPage, memColumn}] <= memWrData;
    assign memRdData = mem[{memPage, memColumn}];
endmodule // lcdc_mem_model
`default_nettype wire

//--- lcd_driver_control_commands_tb.sv
/* Self-checking bench for lcdc_top, one task per scenario.
 Assumes lcdc_pkg and lcdc_mem_model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module lcd_driver_control_commands_tb;
    logic ref_clk = 1'h0, srst = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, ta, tw;
    logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, memRdData, memWrData, memColumn;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hF, memPage;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, memWrEn;
    logic oscRun, supplyRun, boosterRun, driveOn, segmentReverse;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [2:0] boostMult, biasSel;
    logic [5:0] startLine, inversionCount;
    logic [6:0] dutyLines;
    logic [7:0] referenceLevel;
    int n_errors = 0, compares = 0, cyc = 0;
    lcdc_top lcdc_top_i (.*);
    lcdc_mem_model lcdc_mem_model_i (.*);
    // Clock and hang guard
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    // Handshakes sampled 1 ns after the previous edge, so no race with ready
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'h1; s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1; #1;
        while (s_axi_awvalid | s_axi_wvalid) begin
            ta = s_axi_awready; tw = s_axi_wready; @(posedge ref_clk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
            #1;
        end
        while (s_axi_bvalid !== 1'h1) begin @(posedge ref_clk); #1; end
        rr = s_axi_bresp; @(posedge ref_clk); s_axi_bready <= 1'h0; #1;
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a; s_axi_arvalid <= 1'h1; s_axi_rready <= 1'h1; #1;
        while (s_axi_arvalid) begin
            ta = s_axi_arready; @(posedge ref_clk);
            if (ta) s_axi_arvalid <= 1'h0;
            #1;
        end
        while (s_axi_rvalid !== 1'h1) begin @(posedge ref_clk); #1; end
        rv = s_axi_rdata; rr = s_axi_rresp; @(posedge ref_clk); s_axi_rready <= 1'h0; #1;
    endtask
    task automatic cmd(input logic [7:0] c); wr(lcdc_pkg::ADDR_CMD, {24'h000000, c}); endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_boost();
        for (int i = 0; i < 4; i++) begin
            cmd({lcdc_pkg::OP_BOOST, 2'(i)}); chk(boostMult, 3'h2 + 3'(i));
        end
        wr(lcdc_pkg::ADDR_CFG, 32'h000300FF); cmd(8'h33); chk(boostMult, 3'h3);
    endtask
    task automatic t_rmw(); // Column 5, enter, write, read, end, plain read
        cmd(8'h05); cmd(8'h10); cmd(8'hE0); wr(lcdc_pkg::ADDR_DATA, 32'h5A); chk(memColumn, 8'h06);
        rd(lcdc_pkg::ADDR_DATA); chk(memColumn, 8'h06);
        cmd(8'hE1); chk(memColumn, 8'h05);
        rd(lcdc_pkg::ADDR_DATA); chk(memColumn, 8'h06);
    endtask
    task automatic t_swreset(); // Disturb every field but duty, then the reset instruction
        wr(lcdc_pkg::ADDR_CFG, 32'h00050A80); cmd(8'hB3); cmd(8'h41); cmd(8'h31); cmd(8'hA8);
        chk(referenceLevel, 8'h80); cmd(lcdc_pkg::OP_RESET); chk(memColumn, 8'h00);
        chk({memPage, startLine}, 10'h000); chk(referenceLevel, 8'hFF);
        chk({biasSel, boostMult, inversionCount, dutyLines}, {3'h6, 3'h5, 6'h00, 7'h58});
        chk(lcdc_mem_model_i.mem[5], 8'h5A);
    endtask
    task automatic t_psave(); // Internal supply only, drive on, power save, release
        cmd(8'h21); chk(supplyRun, 1'h1); cmd(8'h23); chk(driveOn, 1'h1);
        cmd(8'hAE); chk(oscRun, 1'h1); cmd(8'hA5);
        chk({oscRun, supplyRun, boosterRun, driveOn}, 4'h0);
        cmd(8'hA4); chk(oscRun, 1'h1); chk(driveOn, 1'h0); cmd(8'h23); chk(driveOn, 1'h1);
        cmd(8'hA1); chk(segmentReverse, 1'h1); cmd(8'hA0); chk(segmentReverse, 1'h0);
    endtask
    task automatic t_serial(); // Serial pin setting blocks readback; bad address refused
        wr(lcdc_pkg::ADDR_PINS, 32'h0); rd(lcdc_pkg::ADDR_STATUS); chk(rv, 32'h0);
        rd(lcdc_pkg::ADDR_DATA); chk(rv, 32'h0); wr(lcdc_pkg::ADDR_PINS, 32'h1);
        rd(8'h40); chk(rr, lcdc_pkg::RESP_SLVERR);
        wr(8'h40, 32'h0); chk(rr, lcdc_pkg::RESP_SLVERR);
    endtask
    task automatic stop_test();
        $display("n_errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Main sequence after three cycles of reset
    initial begin
        repeat (3) @(posedge ref_clk);
        srst <= 1'h0; @(posedge ref_clk); #1;
        chk({referenceLevel, biasSel, boostMult, memColumn}, {8'hFF, 3'h6, 3'h5, 8'h00});
        t_boost(); t_rmw(); t_swreset(); t_psave(); t_serial();
        stop_test();
    end
endmodule // lcd_driver_control_commands_tb
`default_nettype wire
